// >>> dma_xfer_pkg.sv
// dma_xfer_pkg: register map, field layout, reset values and encodings of the
// per-channel transfer parameter block.
// assumes a single 32-bit register port on one clock.
package dma_xfer_pkg;
    localparam int          ADDR_W            = 12;
    // register byte addresses (channel 0)
    localparam logic [11:0] SRC_ADDR_OFF      = 12'h0304;
    localparam logic [11:0] DST_ADDR_OFF      = 12'h030c;
    localparam logic [11:0] XFER_CTRL_OFF     = 12'h0314;
    localparam logic [11:0] CPP_OFF           = 12'h031c;
    localparam logic [11:0] CHAN_CTRL_OFF     = 12'h0320;
    // transfer control field positions
    localparam int          SOURCE_PORT_SELECT_LSB      = 30;
    localparam int          DEST_PORT_SELECT_LSB      = 28;
    localparam int          ENDIAN_LSB        = 26;
    localparam int          BC_W              = 24;
    // command packet pointer field positions
    localparam int          NCP_LSB           = 5;
    localparam int          LAST_BIT          = 0;
    // channel control bit positions
    localparam int          GO_BIT            = 31;
    localparam int          CHAIN_BIT         = 30;
    localparam int          ACTIVE_BIT        = 23;
    // reset values
    localparam logic [31:0] ADDR_RST          = 32'h0000_0000;
    localparam logic [23:0] BC_RST            = 24'h00_0000;
    localparam logic [1:0]  PORT_RST          = 2'h0;
    localparam logic [1:0]  ENDIAN_RST        = 2'h2;
    // port encodings
    localparam logic [1:0]  PORT_PCI1         = 2'h0;
    localparam logic [1:0]  PORT_PCI2         = 2'h1;
    localparam logic [1:0]  PORT_PROC         = 2'h2;
    localparam logic [1:0]  PORT_RSVD         = 2'h3;
    // endian conversion modes
    localparam logic [1:0]  END_LITTLE        = 2'h0;
    localparam logic [1:0]  END_PROC_LITTLE   = 2'h1;
    localparam logic [1:0]  END_BIG           = 2'h2;
    localparam logic [1:0]  END_TRUE_LITTLE   = 2'h3;
    localparam int          BEAT_BYTES        = 8;
    localparam int          FIFO_DEPTH        = 32;
    // engine states
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_DIRECT, ST_NEXT} eng_state_t;
endpackage : dma_xfer_pkg

// >>> dma_beat_fifo.sv
// dma_beat_fifo: synchronous FIFO carrying beats from the source side to the
// destination side. one clock; valid/ready on both sides.
module dma_beat_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // full and empty straight from the occupancy count
    // depth compared at count width: a pointer-width cast of 32 would wrap to 0
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
            if (pop)  rd_ptr_reg <= rd_ptr_reg + AW'(1);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dma_beat_fifo

// >>> dma_transfer_params.sv
// dma_transfer_params: one DMA channel's transfer parameters (source and
// destination address, transfer control, command packet pointer) with the
// small engine that advances them and a beat FIFO in the data path.
// assumes a register port with one-cycle strobes, read data one cycle later,
// and a memory side that answers packet fetches and moves 8-byte beats.
// Operation
// - destination address register per channel
// - writes ignored while channel active
// - engine updates registers showing progress
// - store dest bits 31:3, low bits from source
// - source port 00 pci1 01 pci2 10 proc
// - destination port same encoding as source
// - single-pci variant: codes 01, 11 reserved
// - endian mode on proc-pci, resets to 10
// - equal ports force little-endian conversion
// - nonzero count in list mode: direct first
// - byte count tracks bytes remaining
// - next packet pointer bits 31:5, 32-byte aligned
// - last flag: 0 more, 1 final item
// - pointer loaded at list start, then constant; here reloaded from each fetched packet
// - direct by software, list mode loads packets
// - chain bit 0 direct, 1 linked list
// - source address on source port bus; here no source address output, only dst_beat_addr leaves the block
//
// Our own choice: the address-and-strobe port.
module dma_transfer_params
    import dma_xfer_pkg::*;
#(
    parameter bit SINGLE_PCI = 1'b0,
    parameter int DATA_W     = 64,
    parameter int DEPTH      = FIFO_DEPTH
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              first_pci_reset_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // command packet fetch
    output logic                   pkt_req,
    output logic      [31:0]       pkt_addr,
    output logic                   pkt_port,
    input  wire logic              pkt_valid,
    input  wire logic [31:0]       pkt_src_addr,
    input  wire logic [31:0]       pkt_dst_addr,
    input  wire logic [31:0]       pkt_xfer_ctrl,
    input  wire logic [31:0]       pkt_next_ptr,
    input  wire logic              packet_list_port,
    // source beats in, destination beats out
    input  wire logic              src_valid,
    output logic                   src_ready,
    input  wire logic [DATA_W-1:0] src_data,
    output logic                   dst_valid,
    input  wire logic              dst_ready,
    output logic      [DATA_W-1:0] dst_data,
    output logic      [31:0]       dst_beat_addr,
    output logic      [1:0]        source_port_select,
    output logic      [1:0]        dest_port_select,
    output logic      [1:0]        endian_effective,
    output logic                   port_select_error,
    output logic                   channel_active,
    output logic                   transfer_done
);
    logic [31:0]   source_address_reg;
    logic [31:3]   dest_byte_address_reg;
    logic [1:0]    source_port_select_reg;
    logic [1:0]    dest_port_select_reg;
    logic [1:0]    endian_reg;
    logic [BC_W-1:0] byte_count_reg;
    logic [31:5]   next_packet_address_reg;
    logic          last_item_reg;
    logic          chain_reg;
    logic          pkt_req_reg;
    logic          done_reg;
    logic [31:0]   rdata_reg;
    eng_state_t    state_reg;
    eng_state_t    state_next;

    // decode: one-hot selects per register
    wire sel_src  = (reg_addr == SRC_ADDR_OFF);
    wire sel_dst  = (reg_addr == DST_ADDR_OFF);
    wire sel_xc   = (reg_addr == XFER_CTRL_OFF);
    wire sel_cpp  = (reg_addr == CPP_OFF);
    wire sel_cc   = (reg_addr == CHAN_CTRL_OFF);
    wire active   = (state_reg != ST_IDLE);
    // parameter writes only land while idle; engine owns them otherwise
    wire wr_ok    = reg_wr && !active;
    wire go       = reg_wr && sel_cc && reg_wdata[GO_BIT] && !active;
    wire go_chain = reg_wdata[CHAIN_BIT];

    // read-back view of each register, low destination bits mirror the source
    wire [31:0] dst_view = {dest_byte_address_reg, source_address_reg[2:0]};
    wire [31:0] xc_view  = {source_port_select_reg, dest_port_select_reg, endian_reg, 2'h0, byte_count_reg};
    wire [31:0] cpp_view = {next_packet_address_reg, 4'h0, last_item_reg};
    wire [31:0] cc_view  = 32'({chain_reg, 7'h00, active}) << ACTIVE_BIT;
    wire [31:0] rd_mux   = sel_src ? source_address_reg :
                           sel_dst ? dst_view :
                           sel_xc  ? xc_view :
                           sel_cpp ? cpp_view :
                           sel_cc  ? cc_view : 32'h0000_0000;

    // port codes not present on this variant are flagged, never remapped
    function automatic logic port_bad(input logic [1:0] p);
        port_bad = (p == PORT_RSVD) || (SINGLE_PCI && p == PORT_PCI2);
    endfunction : port_bad

    // beat movement: one beat is consumed per accepted destination beat
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire moving      = (state_reg == ST_DIRECT);
    wire beat_done   = dst_valid && dst_ready;
    wire [BC_W-1:0] step = (byte_count_reg > BC_W'(BEAT_BYTES)) ? BC_W'(BEAT_BYTES) : byte_count_reg;
    wire count_empty = (byte_count_reg == BC_RST);
    // destination moves by the same step as the source so the low bits stay paired
    wire [31:0] dst_step = dst_view + 32'(step);

    assign src_ready          = moving && fifo_in_ready;
    assign dst_valid          = moving && fifo_out_valid && !count_empty;
    assign dst_beat_addr      = dst_view;
    assign source_port_select = source_port_select_reg;
    assign dest_port_select   = dest_port_select_reg;
    // same-port moves are always little-endian
    assign endian_effective   = (source_port_select_reg == dest_port_select_reg) ? END_LITTLE : endian_reg;
    assign port_select_error  = port_bad(source_port_select_reg) || port_bad(dest_port_select_reg);
    assign pkt_req            = pkt_req_reg;
    assign pkt_addr           = cpp_view & 32'hffff_ffe0;
    assign pkt_port           = packet_list_port;
    assign channel_active     = active;
    assign transfer_done      = done_reg;
    assign reg_rdata          = rdata_reg;

    dma_beat_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (src_valid && moving),
        .in_ready  (fifo_in_ready),
        .in_data   (src_data),
        .out_valid (fifo_out_valid),
        .out_ready (beat_done),
        .out_data  (dst_data)
    );

    // engine sequencing: direct run, then packet fetches while list continues
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (go) begin
                    // nonzero count in list mode runs a direct pass first
                    if (!go_chain || !count_empty) state_next = ST_DIRECT;
                    else                           state_next = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (pkt_valid) state_next = ST_DIRECT;
            end
            ST_DIRECT: begin
                if (count_empty && !fifo_out_valid) state_next = ST_NEXT;
            end
            ST_NEXT: begin
                if (chain_reg && !last_item_reg) state_next = ST_FETCH;
                else                             state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= ST_IDLE;
            pkt_req_reg <= 1'b0;
            done_reg    <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            state_reg   <= state_next;
            pkt_req_reg <= (state_next == ST_FETCH) && !pkt_valid;
            done_reg    <= (state_reg == ST_NEXT) && (state_next == ST_IDLE);
            rdata_reg   <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // chain mode latches on every idle channel control write, go or not, and stays for the whole run
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chain_reg <= 1'b0;
        end else if (reg_wr && sel_cc && !active) begin
            chain_reg <= reg_wdata[CHAIN_BIT];
        end
    end

    // addresses and count: software while idle, engine while running
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            source_address_reg    <= ADDR_RST;
            dest_byte_address_reg <= ADDR_RST[31:3];
            source_port_select_reg          <= PORT_RST;
            dest_port_select_reg          <= PORT_RST;
            byte_count_reg        <= BC_RST;
        end else if (state_reg == ST_FETCH && pkt_valid) begin
            source_address_reg    <= pkt_src_addr;
            dest_byte_address_reg <= pkt_dst_addr[31:3];
            source_port_select_reg          <= pkt_xfer_ctrl[SOURCE_PORT_SELECT_LSB +: 2];
            dest_port_select_reg          <= pkt_xfer_ctrl[DEST_PORT_SELECT_LSB +: 2];
            byte_count_reg        <= pkt_xfer_ctrl[BC_W-1:0];
        end else if (beat_done) begin
            // progress is visible through the same registers
            source_address_reg    <= source_address_reg + 32'(step);
            dest_byte_address_reg <= dst_step[31:3];
            byte_count_reg        <= byte_count_reg - step;
        end else if (wr_ok) begin
            if (sel_src) source_address_reg    <= reg_wdata;
            if (sel_dst) dest_byte_address_reg <= reg_wdata[31:3];
            if (sel_xc) begin
                source_port_select_reg   <= reg_wdata[SOURCE_PORT_SELECT_LSB +: 2];
                dest_port_select_reg   <= reg_wdata[DEST_PORT_SELECT_LSB +: 2];
                byte_count_reg <= reg_wdata[BC_W-1:0];
            end
        end
    end

    // endian mode lives on the first pci reset, not the global one
    always_ff @(posedge clk_sys or negedge first_pci_reset_n) begin
        if (!first_pci_reset_n) begin
            endian_reg <= ENDIAN_RST;
        end else if (state_reg == ST_FETCH && pkt_valid) begin
            endian_reg <= pkt_xfer_ctrl[ENDIAN_LSB +: 2];
        end else if (wr_ok && sel_xc) begin
            endian_reg <= reg_wdata[ENDIAN_LSB +: 2];
        end
    end

    // pointer: loaded from each fetched packet, held constant during its run
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            next_packet_address_reg <= ADDR_RST[31:5];
            last_item_reg           <= 1'b0;
        end else if (state_reg == ST_FETCH && pkt_valid) begin
            next_packet_address_reg <= pkt_next_ptr[31:NCP_LSB];
            last_item_reg           <= pkt_next_ptr[LAST_BIT];
        end else if (wr_ok && sel_cpp) begin
            next_packet_address_reg <= reg_wdata[31:NCP_LSB];
            last_item_reg           <= reg_wdata[LAST_BIT];
        end
    end
endmodule : dma_transfer_params

// >>> dma_transfer_params_asserts.sv
// checker: port-level assertions for the transfer parameter block
// assumes one clock and an async active-low reset; bound from the bench top
module dma_transfer_params_asserts
    import dma_xfer_pkg::*;
#(
    parameter bit SINGLE_PCI = 1'b0
) (
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              pkt_req,
    input wire logic              pkt_valid,
    input wire logic [31:0]       pkt_addr,
    input wire logic              pkt_port,
    input wire logic              packet_list_port,
    input wire logic              dst_valid,
    input wire logic              dst_ready,
    input wire logic [31:0]       dst_beat_addr,
    input wire logic [1:0]        source_port_select,
    input wire logic [1:0]        dest_port_select,
    input wire logic [1:0]        endian_effective,
    input wire logic              port_select_error,
    input wire logic              channel_active
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // a beat or a fetch may move the address legally, so only quiet cycles count
    wire quiet = !(dst_valid && dst_ready) && !pkt_valid;
    wire is3   = (source_port_select == 2'h3) || (dest_port_select == 2'h3);
    wire is1   = (source_port_select == 2'h1) || (dest_port_select == 2'h1);
    a_pkt_aligned: assert property (pkt_addr[4:0] == 5'h00)
        else $error("packet fetch address not aligned");
    a_pkt_port: assert property (pkt_port == packet_list_port)
        else $error("packet port does not follow attribute bit");
    a_endian_same: assert property (source_port_select == dest_port_select |-> endian_effective == END_LITTLE)
        else $error("equal ports without little-endian");
    a_port_error: assert property (port_select_error == (is3 || (SINGLE_PCI && is1)))
        else $error("port error flag wrong");
    a_write_ignored: assert property (channel_active && reg_wr && reg_addr == DST_ADDR_OFF && quiet |=> $stable(dst_beat_addr))
        else $error("write while active changed address");
    // full beats move 8 bytes; only a short last beat, after which valid drops, moves less
    a_beat_step: assert property (dst_valid && dst_ready |=>
        (dst_beat_addr - $past(dst_beat_addr)) == 32'h0000_0008 ||
        (!dst_valid && (dst_beat_addr - $past(dst_beat_addr)) inside {[32'h0000_0001:32'h0000_0007]}))
        else $error("address did not advance by a beat");
    a_fetch_hold: assert property (pkt_req && !pkt_valid |=> pkt_req)
        else $error("fetch request dropped early");
    a_fetch_drop: assert property (pkt_req && pkt_valid |=> !pkt_req)
        else $error("fetch request held after packet");
    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule : dma_transfer_params_asserts

// >>> far_side_model.sv
// far side model: memory answering packet fetches, source and destination ports
// assumes one clock; the bench loads source beats and picks prompt or slow timing
module far_side_model #(
    parameter logic [31:0] P_SRC  = 32'h0000_4000,
    parameter logic [31:0] P_DST  = 32'h0000_3000,
    parameter logic [31:0] P_CTRL = 32'h8800_0008,
    parameter logic [31:0] P_NEXT = 32'h0000_0001
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        load,
    input  wire logic [7:0]  beats,
    input  wire logic        pkt_req,
    output logic             pkt_valid,
    output logic      [31:0] pkt_src_addr,
    output logic      [31:0] pkt_dst_addr,
    output logic      [31:0] pkt_xfer_ctrl,
    output logic      [31:0] pkt_next_ptr,
    output logic             src_valid,
    input  wire logic        src_ready,
    output logic      [63:0] src_data,
    output logic             dst_ready
);
    logic [3:0]  wait_reg;
    logic [7:0]  left_reg;
    logic [63:0] beat_reg;
    logic        tog_reg;
    // packet words mean something only with pkt_valid; elsewhere they show garbage
    assign pkt_valid     = pkt_req && (wait_reg == (slow ? 4'h5 : 4'h1));
    assign pkt_src_addr  = pkt_valid ? P_SRC : ~P_SRC;
    assign pkt_dst_addr  = pkt_valid ? P_DST : ~P_DST;
    assign pkt_xfer_ctrl = pkt_valid ? P_CTRL : ~P_CTRL;
    assign pkt_next_ptr  = pkt_valid ? P_NEXT : ~P_NEXT;
    assign src_valid     = (left_reg != 8'h00);
    assign src_data      = src_valid ? beat_reg : ~beat_reg;
    assign dst_ready     = !slow || tog_reg; // slow mode stalls every other cycle
    // fetch latency, beat supply; a packet brings exactly one beat of its own
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wait_reg <= 4'h0;
            left_reg <= 8'h00;
            beat_reg <= 64'h0000_0000_0000_0100;
            tog_reg  <= 1'b0;
        end else begin
            wait_reg <= (pkt_req && !pkt_valid) ? wait_reg + 4'h1 : 4'h0;
            tog_reg  <= !tog_reg;
            if (load) left_reg <= beats;
            else if (pkt_valid) left_reg <= left_reg + 8'h01;
            else if (src_valid && src_ready) left_reg <= left_reg - 8'h01;
            if (src_valid && src_ready) beat_reg <= beat_reg + 64'h0000_0000_0000_0001;
        end
    end
endmodule : far_side_model

// >>> tb_dma_transfer_params.sv
// bench for the transfer parameter block with the far side model
// assumes the package's register map; inputs change by NBA at rising edges or one step after them
module tb_dma_transfer_params
    import dma_xfer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic              clk_sys, rstn, first_pci_reset_n, reg_wr, reg_rd, packet_list_port, load, slow;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, pkt_addr, ps, pd, pc, pn, dst_beat_addr, fetch_addr;
    logic              pkt_req, pkt_port, pkt_valid, src_valid, src_ready, dst_valid, dst_ready;
    logic [63:0]       src_data, dst_data, exp_data;
    logic [1:0]        sps, dps, endian_effective;
    logic              port_select_error, channel_active, transfer_done;
    logic [7:0]        beats;
    int                miscompares, n_tests, cycles, n_beats, beats_at_fetch;
    row_t              rows [5] = '{'{SRC_ADDR_OFF, 32'h0000_0005, 32'h0000_0005},
        '{DST_ADDR_OFF, 32'hABCD_EF08, 32'hABCD_EF0D}, '{XFER_CTRL_OFF, 32'h4C00_0010, 32'h4C00_0010},
        '{CPP_OFF, 32'h1234_5679, 32'h1234_5661}, '{12'h0400, 32'hFFFF_FFFF, 32'h0000_0000}};
    dma_transfer_params i_dut (.clk_sys(clk_sys), .rstn(rstn), .first_pci_reset_n(first_pci_reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pkt_req(pkt_req), .pkt_addr(pkt_addr), .pkt_port(pkt_port), .pkt_valid(pkt_valid),
        .pkt_src_addr(ps), .pkt_dst_addr(pd), .pkt_xfer_ctrl(pc), .pkt_next_ptr(pn),
        .packet_list_port(packet_list_port), .src_valid(src_valid), .src_ready(src_ready),
        .src_data(src_data), .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
        .dst_beat_addr(dst_beat_addr), .source_port_select(sps), .dest_port_select(dps),
        .endian_effective(endian_effective), .port_select_error(port_select_error),
        .channel_active(channel_active), .transfer_done(transfer_done));
    far_side_model i_far (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .load(load), .beats(beats),
        .pkt_req(pkt_req), .pkt_valid(pkt_valid), .pkt_src_addr(ps), .pkt_dst_addr(pd), .pkt_xfer_ctrl(pc),
        .pkt_next_ptr(pn), .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
        .dst_ready(dst_ready));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // sampled mid-cycle so handshakes are settled; also the hang limit
    always @(negedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
        if (pkt_req && pkt_valid) begin
            fetch_addr = pkt_addr;
            beats_at_fetch = n_beats;
        end
        if (dst_valid && dst_ready) begin
            chk(dst_data, exp_data);
            exp_data += 64'h0000_0000_0000_0001;
            n_beats++;
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus cycle, write or read; returns one step after the data edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(reg_rdata, e);
    endtask : rd
    // bounded wait; a hung engine shows up as a failed compare, not a stall
    task automatic wait_done;
        int k;
        k = 0;
        while (transfer_done !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        chk(k < 400, 1'b1);
    endtask : wait_done
    task automatic give_verdict;
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        {rstn, first_pci_reset_n, reg_wr, reg_rd, packet_list_port, load, slow} = 7'h00;
        {reg_addr, reg_wdata, beats} = '0;
        exp_data = 64'h0000_0000_0000_0100;
        repeat (2) @(posedge clk_sys);
        {rstn, first_pci_reset_n} <= 2'b11;
        rd(DST_ADDR_OFF, 32'h0000_0000);
        rd(XFER_CTRL_OFF, 32'h0800_0000);
        rd(CPP_OFF, 32'h0000_0000);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                bus(1'b1, XFER_CTRL_OFF, {s[1:0], d[1:0], END_PROC_LITTLE, 26'h000_0000});
                chk(sps, s[1:0]);
                chk(dps, d[1:0]);
                chk(endian_effective, (s == d) ? END_LITTLE : END_PROC_LITTLE);
                chk(port_select_error, s == 3 || d == 3);
            end
        end
        // direct run of 20 bytes with a stalling destination: beats of 8, 8 and 4
        bus(1'b1, SRC_ADDR_OFF, 32'h0000_2000);
        bus(1'b1, DST_ADDR_OFF, 32'h0000_1000);
        bus(1'b1, XFER_CTRL_OFF, 32'h8800_0014);
        {beats, slow, load} <= {8'h03, 2'b11};
        bus(1'b1, CHAN_CTRL_OFF, 32'h8000_0000);
        load <= 1'b0;
        bus(1'b1, DST_ADDR_OFF, 32'h5555_5550);
        chk(channel_active, 1'b1);
        wait_done;
        rd(DST_ADDR_OFF, 32'h0000_1014);
        rd(XFER_CTRL_OFF, 32'h8800_0000);
        chk(n_beats, 3);
        // list run: one direct beat first, then a fetched packet marked last
        packet_list_port <= 1'b1;
        bus(1'b1, CPP_OFF, 32'h0000_0100);
        bus(1'b1, XFER_CTRL_OFF, 32'h8800_0008);
        {beats, slow, load} <= {8'h01, 2'b01};
        bus(1'b1, CHAN_CTRL_OFF, 32'hC000_0000);
        load <= 1'b0;
        wait_done;
        chk(fetch_addr, 32'h0000_0100);
        chk(beats_at_fetch, 4);
        chk(n_beats, 5);
        rd(DST_ADDR_OFF, 32'h0000_3008);
        rd(CPP_OFF, 32'h0000_0001);
        // the endian field survives the global reset and only the other one resets it to 10
        bus(1'b1, XFER_CTRL_OFF, 32'h0C00_0000);
        rstn <= 1'b0;
        bus(1'b0, 12'h0400, 32'h0000_0000);
        rstn <= 1'b1;
        rd(XFER_CTRL_OFF, 32'h0C00_0000);
        first_pci_reset_n <= 1'b0;
        bus(1'b0, 12'h0400, 32'h0000_0000);
        first_pci_reset_n <= 1'b1;
        rd(XFER_CTRL_OFF, 32'h0800_0000);
        give_verdict();
    end
endmodule : tb_dma_transfer_params
bind dma_transfer_params dma_transfer_params_asserts #(.SINGLE_PCI(SINGLE_PCI)) i_chk (.clk_sys(clk_sys),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pkt_req(pkt_req), .pkt_valid(pkt_valid), .pkt_addr(pkt_addr), .pkt_port(pkt_port),
    .packet_list_port(packet_list_port), .dst_valid(dst_valid), .dst_ready(dst_ready),
    .dst_beat_addr(dst_beat_addr), .source_port_select(source_port_select),
    .dest_port_select(dest_port_select), .endian_effective(endian_effective),
    .port_select_error(port_select_error), .channel_active(channel_active));
